// ---- logic/bct_cycle_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module bct_cycle_timer
	import bct_pkg::*;
#(
	parameter int unsigned CLK_HZ = CLK_FREQ_HZ,
	parameter int unsigned TICK_HZ = TICK_FREQ_HZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_cycle_pulse_in,
	input wire logic cycle_start_valid,
	input wire logic [31:0] cycle_start_time,
	output logic cycle_rollover
);
	// Layout checks: a gap or overlap between fields would lose carries
	initial begin
		if (TICK_HZ == 0 || TICK_HZ > CLK_HZ) begin
			$error("bct_cycle_timer: tick rate must be nonzero, not above clock");
		end
		// The accumulator sum must not overflow its 32 bits
		if (CLK_HZ >= 32'h8000_0000) begin
			$error("bct_cycle_timer: clock rate too high for the accumulator");
		end
		if (SEC_W + CNUM_W + COFF_W != 32) begin
			$error("bct_cycle_timer: time fields must fill 32 bits");
		end
		if (CNUM_LSB != SEC_LSB + SEC_W || COFF_LSB != CNUM_LSB + CNUM_W) begin
			$error("bct_cycle_timer: time fields must be contiguous");
		end
		if (BUS_SEC_LSB != BUS_EXT_W || BUS_EXT_W + SEC_W != 32) begin
			$error("bct_cycle_timer: bus time fields must fill 32 bits");
		end
		if (BUS_EXT_W > 31) begin
			$error("bct_cycle_timer: extension must leave room for seconds");
		end
		if (COFF_LAST == '0 || CNUM_LAST == '0 || SEC_LAST == '0) begin
			$error("bct_cycle_timer: wrap points must be nonzero");
		end
		if (EXT_PULSE_MIN_CYC < 1) begin
			$error("bct_cycle_timer: pulse width must be at least one clock");
		end
		// Decoding relies on unique, aligned offsets
		if (ADDR_CYCLE_TIME == ADDR_BUS_TIME ||
			ADDR_CYCLE_TIME == ADDR_LINK_CTRL ||
			ADDR_BUS_TIME == ADDR_LINK_CTRL) begin
			$error("bct_cycle_timer: register offsets must differ");
		end
		if (ADDR_CYCLE_TIME[1:0] != 2'h0 || ADDR_BUS_TIME[1:0] != 2'h0 ||
			ADDR_LINK_CTRL[1:0] != 2'h0) begin
			$error("bct_cycle_timer: register offsets must be word aligned");
		end
		if (LC_ENABLE_BIT == LC_MASTER_BIT || LC_MASTER_BIT == LC_EXTSRC_BIT ||
			LC_EXTSRC_BIT == LC_SWRESET_BIT || LC_SWRESET_BIT > 31) begin
			$error("bct_cycle_timer: link control bits must be distinct");
		end
	end

	// Fractional accumulator: average tick rate is exact, jitter one clock
	localparam int unsigned ACC_W = 32;
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(TICK_HZ);
	localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_HZ);

	logic [31:0] cycle_time_count_reg;
	logic [BUS_EXT_W-1:0] bus_seconds_extension_reg;
	logic cycle_timer_enable_reg;
	logic cycle_master_select_reg;
	logic external_cycle_source_select_reg;
	logic [ACC_W-1:0] acc_reg;
	logic int_tick;
	logic ext_tick;
	logic step;
	logic wrap_all;
	logic [31:0] ct_next;
	logic wr_access;
	logic rd_access;
	logic soft_reset;

	logic ctrl_wr;
	logic cyc_wr;
	logic bus_wr;
	logic cs_load;
	logic mapped;
	logic [ACC_W-1:0] acc_sum;
	logic acc_carry;
	logic [BUS_EXT_W-1:0] ext_next;
	logic [31:0] read_next;

	// Shared by the step function and the wrap detector
	function automatic logic offset_done(input logic [31:0] t);
		return t[COFF_LSB +: COFF_W] >= COFF_LAST;
	endfunction : offset_done

	function automatic logic cycle_done(input logic [31:0] t);
		return t[CNUM_LSB +: CNUM_W] >= CNUM_LAST;
	endfunction : cycle_done

	function automatic logic [31:0] advance(input logic [31:0] t);
		logic [SEC_W-1:0] s;
		logic [CNUM_W-1:0] n;
		logic [COFF_W-1:0] o;
		s = t[SEC_LSB +: SEC_W];
		n = t[CNUM_LSB +: CNUM_W];
		o = t[COFF_LSB +: COFF_W];
		if (offset_done(t)) begin
			o = '0;
			if (cycle_done(t)) begin
				n = '0;
				s = s + SEC_W'(1);
			end else begin
				n = n + CNUM_W'(1);
			end
		end else begin
			o = o + COFF_W'(1);
		end
		return {o, n, s};
	endfunction : advance

	function automatic logic is_last(input logic [31:0] t);
		return offset_done(t) && cycle_done(t) &&
			t[SEC_LSB +: SEC_W] == SEC_LAST;
	endfunction : is_last

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction : hit

	assign wr_access = psel && penable && pwrite;
	assign rd_access = psel && !penable && !pwrite;
	assign ctrl_wr = wr_access && hit(paddr, ADDR_LINK_CTRL);
	assign cyc_wr = wr_access && hit(paddr, ADDR_CYCLE_TIME);
	assign bus_wr = wr_access && hit(paddr, ADDR_BUS_TIME);
	// Soft reset also takes the written mode bits in the same write
	assign soft_reset = ctrl_wr && pwdata[LC_SWRESET_BIT];
	assign mapped = hit(paddr, ADDR_CYCLE_TIME) || hit(paddr, ADDR_BUS_TIME) ||
		hit(paddr, ADDR_LINK_CTRL);
	// Loads only while another node is master
	assign cs_load = cycle_timer_enable_reg && !cycle_master_select_reg &&
		cycle_start_valid;

	// Pin is asynchronous; the detector carries its own synchroniser
	bct_pulse_detect #(
		.MIN_CYC(EXT_PULSE_MIN_CYC)
	) u_pulse (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.pulse_in(external_cycle_pulse_in),
		.pulse_event(ext_tick)
	);

	assign acc_sum = acc_reg + ACC_STEP;
	assign acc_carry = acc_sum >= ACC_MOD;

	// Accumulator stays below ACC_MOD, so the sum never overflows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_reg <= '0;
		end else if (clk_en) begin
			if (acc_carry) begin
				acc_reg <= acc_sum - ACC_MOD;
			end else begin
				acc_reg <= acc_sum;
			end
		end
	end

	// Registered tick: one clock of latency, no long combinational path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_tick <= 1'b0;
		end else if (clk_en) begin
			int_tick <= acc_carry;
		end
	end

	// Master bit only decides whether cycle start loads apply
	always_comb begin
		step = 1'b0;
		if (!cycle_timer_enable_reg) begin
			step = 1'b0;
		end else if (external_cycle_source_select_reg) begin
			if (cycle_master_select_reg) begin
				step = ext_tick;
			end else begin
				step = ext_tick;
			end
		end else begin
			if (cycle_master_select_reg) begin
				step = int_tick;
			end else begin
				step = int_tick;
			end
		end
	end

	// Extension rolls over silently after its full range
	always_comb begin
		ext_next = bus_seconds_extension_reg;
		if (wrap_all && cycle_timer_enable_reg) begin
			ext_next = bus_seconds_extension_reg +
				BUS_EXT_W'(1);
		end
	end
	assign wrap_all = step && is_last(cycle_time_count_reg);
	assign ct_next = advance(cycle_time_count_reg);

	// One block per control bit; a single write sets all three together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycle_timer_enable_reg <= LINK_CTRL_RESET[LC_ENABLE_BIT];
		end else if (clk_en && ctrl_wr) begin
			cycle_timer_enable_reg <= pwdata[LC_ENABLE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycle_master_select_reg <= LINK_CTRL_RESET[LC_MASTER_BIT];
		end else if (clk_en && ctrl_wr) begin
			cycle_master_select_reg <= pwdata[LC_MASTER_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			external_cycle_source_select_reg <= LINK_CTRL_RESET[LC_EXTSRC_BIT];
		end else if (clk_en && ctrl_wr) begin
			external_cycle_source_select_reg <= pwdata[LC_EXTSRC_BIT];
		end
	end

	// Software write beats both counting and a cycle start load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycle_time_count_reg <= REG_RESET;
		end else if (clk_en) begin
			if (soft_reset) begin
				cycle_time_count_reg <= REG_RESET;
			end else if (cyc_wr) begin
				cycle_time_count_reg <= pwdata;
			end else if (cs_load) begin
				cycle_time_count_reg <= cycle_start_time;
			end else if (step) begin
				cycle_time_count_reg <= ct_next;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_seconds_extension_reg <= BUS_TIME_RESET[BUS_EXT_W-1:0];
		end else if (clk_en) begin
			if (soft_reset) begin
				bus_seconds_extension_reg <= BUS_TIME_RESET[BUS_EXT_W-1:0];
			end else if (bus_wr) begin
				bus_seconds_extension_reg <= pwdata[BUS_EXT_W-1:0];
			end else begin
				bus_seconds_extension_reg <= ext_next;
			end
		end
	end

	// One-cycle flag so a user can stamp the wrap without polling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycle_rollover <= 1'b0;
		end else if (clk_en) begin
			cycle_rollover <= wrap_all;
		end
	end

	// Unmapped or idle reads give zero, so nothing stale leaks out
	always_comb begin
		read_next = '0;
		if (rd_access) begin
			if (hit(paddr, ADDR_CYCLE_TIME)) begin
				read_next = cycle_time_count_reg;
			end else if (hit(paddr, ADDR_BUS_TIME)) begin
				read_next = {cycle_time_count_reg[SEC_LSB +: SEC_W],
					bus_seconds_extension_reg};
			end else if (hit(paddr, ADDR_LINK_CTRL)) begin
				read_next = {29'h0000_0000, external_cycle_source_select_reg,
					cycle_master_select_reg, cycle_timer_enable_reg};
			end
		end
	end

	// Read data is captured in setup so the access phase sees a register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (clk_en) begin
			prdata <= read_next;
		end
	end

	// Exactly one access cycle: the slave never inserts wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else if (clk_en) begin
			pready <= psel && !penable;
		end
	end

	// Writes to unmapped offsets are dropped, reads return zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pslverr <= psel && !penable && !mapped;
		end
	end
endmodule : bct_cycle_timer
`default_nettype wire

// ---- shared/bct_pkg.sv ----
package bct_pkg;
	localparam int unsigned CLK_FREQ_HZ = 200000000;
	localparam int unsigned TICK_FREQ_HZ = 24576000;
	localparam int unsigned EXT_PULSE_MIN_NS = 80;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned EXT_PULSE_MIN_CYC =
		(EXT_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] ADDR_CYCLE_TIME = 8'h28;
	localparam logic [7:0] ADDR_BUS_TIME = 8'h2c;
	localparam logic [7:0] ADDR_LINK_CTRL = 8'h0c;
	localparam int unsigned SEC_LSB = 0;
	localparam int unsigned SEC_W = 7;
	localparam int unsigned CNUM_LSB = 7;
	localparam int unsigned CNUM_W = 13;
	localparam int unsigned COFF_LSB = 20;
	localparam int unsigned COFF_W = 12;
	localparam int unsigned BUS_EXT_W = 25;
	localparam int unsigned BUS_SEC_LSB = 25;
	localparam logic [11:0] COFF_LAST = 12'hbff;
	localparam logic [12:0] CNUM_LAST = 13'h1f3f;
	localparam logic [6:0] SEC_LAST = 7'h7f;
	localparam int unsigned LC_ENABLE_BIT = 0;
	localparam int unsigned LC_MASTER_BIT = 1;
	localparam int unsigned LC_EXTSRC_BIT = 2;
	localparam int unsigned LC_SWRESET_BIT = 3;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [31:0] BUS_TIME_RESET = 32'h0000_0000;
	localparam logic [2:0] LINK_CTRL_RESET = 3'h0;
endpackage : bct_pkg

// ---- logic/bct_pulse_detect.sv ----
`timescale 1ns/10ps
`default_nettype none
// Synchronises the external cycle pulse and flags one event per valid pulse.
// Pulse counted on its falling edge once it has stood long enough.
module bct_pulse_detect
	import bct_pkg::*;
#(
	parameter int unsigned MIN_CYC = EXT_PULSE_MIN_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic pulse_in,
	output logic pulse_event
);
	localparam int unsigned CW = $clog2(MIN_CYC + 1);
	localparam logic [CW-1:0] MIN_VAL = CW'(MIN_CYC);
	initial begin
		if (MIN_CYC < 1) begin
			$error("bct_pulse_detect: MIN_CYC must be at least one");
		end
	end
	logic sync1_reg;
	logic sync2_reg;
	logic [CW-1:0] width_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else if (clk_en) begin
			sync1_reg <= pulse_in;
			sync2_reg <= sync1_reg;
		end
	end
	// Width counter saturates so a long pulse still yields one event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			width_reg <= '0;
			pulse_event <= 1'b0;
		end else if (clk_en) begin
			pulse_event <= 1'b0;
			if (sync2_reg) begin
				if (width_reg != MIN_VAL) begin
					width_reg <= width_reg + CW'(1);
				end
			end else begin
				pulse_event <= (width_reg == MIN_VAL);
				width_reg <= '0;
			end
		end
	end
endmodule : bct_pulse_detect
`default_nettype wire

// ---- bench/bct_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module bct_checker
	import bct_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cycle_rollover
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic mapped;
	assign mapped = paddr inside {ADDR_CYCLE_TIME, ADDR_BUS_TIME, ADDR_LINK_CTRL};
	sequence setup_s;
		clk_en && psel && !penable;
	endsequence
	sequence access_s;
		pready ##1 !pready;
	endsequence
	// Soft reset write with all mode bits low, so nothing counts afterwards
	sequence soft_rst_s;
		setup_s ##0 pwrite && paddr == ADDR_LINK_CTRL && pwdata == 32'h8 ##1 pready;
	endsequence
	apb_answer_a: assert property (setup_s |=> access_s)
		else $error("no single access");
	ready_cause_a: assert property (pready |-> $past(psel && !penable))
		else $error("stray ready");
	unmapped_err_a: assert property (setup_s ##0 !mapped |=> pslverr && prdata == 0)
		else $error("unmapped not refused");
	mapped_ok_a: assert property (setup_s ##0 mapped |=> !pslverr)
		else $error("mapped refused");
	idle_data_a: assert property (!pready |-> prdata == 32'h0)
		else $error("data outside access");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	roll_pulse_a: assert property (clk_en && cycle_rollover |=> !cycle_rollover)
		else $error("rollover too long");
	soft_clear_a: assert property (soft_rst_s ##2 (setup_s ##0 !pwrite && paddr == ADDR_CYCLE_TIME) |=> prdata == 32'h0)
		else $error("soft reset kept time");
endmodule : bct_checker
`default_nettype wire

// ---- bench/bct_pulse_src.sv ----
`timescale 1ns/10ps
`default_nettype none
module bct_pulse_src (
	input wire logic clk,
	output logic pulse
);
	initial pulse = 1'b0;
	// Idle gap lets the synchroniser and edge logic settle before the next pulse
	task automatic fire(input int len);
		pulse <= 1'b1;
		repeat (len) @(posedge clk);
		pulse <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : fire
endmodule : bct_pulse_src
`default_nettype wire

// ---- bench/bus_cycle_time_counter_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module bus_cycle_time_counter_bench
	import bct_pkg::*;
;
	logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic csv = 0, ext, pready, pslverr, roll;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, cst = 0, prdata, r, t;
	int fail_count = 0, comparisons = 0, roll_cnt = 0, k;
	always @(posedge pclk) if (roll === 1'b1) roll_cnt++;
	int em[3] = '{4, 5, 7};
	int ld[2] = '{1, 5};
	bct_cycle_timer dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_cycle_pulse_in(ext), .cycle_start_valid(csv),
		.cycle_start_time(cst), .cycle_rollover(roll));
	bct_pulse_src src_u (.clk(pclk), .pulse(ext));
	initial forever #2.5 pclk = ~pclk;
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1 && n++ < 20);
		if (pready !== 1'b1) fail_count++;
		r = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb
	function automatic logic [31:0] rnd();
		return {12'($urandom % 3072), 13'($urandom % 8000), 7'($urandom)};
	endfunction : rnd
	function automatic logic [31:0] adv(logic [31:0] t, int n);
		repeat (n) begin
			t[31:20] = (t[31:20] == COFF_LAST) ? 12'h0 : t[31:20] + 12'h1;
			if (t[31:20] == 12'h0) begin
				t[19:7] = (t[19:7] == CNUM_LAST) ? 13'h0 : t[19:7] + 13'h1;
				if (t[19:7] == 13'h0) t[6:0] = t[6:0] + 7'h1;
			end
		end
		return t;
	endfunction : adv
	task end_sim;
		if (fail_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		#100000;
		fail_count++;
		end_sim;
	end
	initial begin
		void'($urandom(61567));
		repeat (20) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, ADDR_CYCLE_TIME, 0);
		`CHK(r, REG_RESET)
		apb(0, ADDR_BUS_TIME, 0);
		`CHK(r, BUS_TIME_RESET)
		apb(0, 8'h10, 0);
		`CHK(r, 32'h0)
		repeat (4) begin
			t = rnd();
			apb(1, ADDR_CYCLE_TIME, t);
			apb(0, ADDR_CYCLE_TIME, 0);
			`CHK(r, t)
			apb(0, ADDR_BUS_TIME, 0);
			`CHK(r[31:25], t[6:0])
		end
		for (int c = 0; c < 4; c++) begin
			apb(1, ADDR_LINK_CTRL, 32'(c));
			apb(1, ADDR_CYCLE_TIME, 0);
			repeat (40) @(posedge pclk);
			apb(0, ADDR_CYCLE_TIME, 0);
			`CHK(r[31:20] != 0, c[0])
		end
		// Clock enable low must freeze the running timer
		apb(1, ADDR_LINK_CTRL, 32'h1);
		apb(1, ADDR_CYCLE_TIME, 0);
		clk_en <= 0;
		repeat (200) @(posedge pclk);
		clk_en <= 1;
		apb(0, ADDR_CYCLE_TIME, 0);
		`CHK(r[31:20] < 12'd8, 1'b1)
		foreach (ld[i]) begin
			apb(1, ADDR_LINK_CTRL, 32'(ld[i]));
			t = rnd() & 32'h7fff_ffff;
			csv <= 1;
			cst <= t;
			@(posedge pclk);
			csv <= 0;
			@(posedge pclk);
			apb(0, ADDR_CYCLE_TIME, 0);
			`CHK(r[19:0], t[19:0])
			`CHK(r[31:20] - t[31:20] < 12'd64, 1'b1)
		end
		// Disabled mode first: pulses must leave both counters alone
		foreach (em[i]) begin
			apb(1, ADDR_LINK_CTRL, 32'(em[i]));
			t = (i == 1) ? {COFF_LAST - 12'h1, CNUM_LAST, SEC_LAST} : rnd();
			apb(1, ADDR_CYCLE_TIME, t);
			apb(1, ADDR_BUS_TIME, 32'h55);
			k = roll_cnt;
			repeat (3) src_u.fire(16);
			src_u.fire(10);
			apb(0, ADDR_CYCLE_TIME, 0);
			`CHK(r, em[i][0] ? adv(t, 3) : t)
			apb(0, ADDR_BUS_TIME, 0);
			`CHK(r[24:0], 25'h55 + 25'(i == 1))
			`CHK(roll_cnt - k, 32'(i == 1))
		end
		apb(1, ADDR_LINK_CTRL, 32'h8);
		apb(0, ADDR_CYCLE_TIME, 0);
		`CHK(r, 32'h0)
		apb(0, ADDR_BUS_TIME, 0);
		`CHK(r, 32'h0)
		end_sim;
	end
endmodule : bus_cycle_time_counter_bench
bind bct_cycle_timer bct_checker chk_u (.pclk(pclk), .presetn(presetn),
	.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .cycle_rollover(cycle_rollover));
`default_nettype wire
